/* logic/cie_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cie_defines.svh"

module cie_core (
  input wire logic clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire cie_pkg::cie_op_t instr_op,
  input wire logic [`CIE_ADDR_W-1:0] instr_file,
  input wire logic instr_dest,
  input wire logic [`CIE_LIT_W-1:0] instr_lit,
  input wire logic [`CIE_LATCH_W-1:0] upper_branch_latch,
  input wire logic [`CIE_ADDR_W-1:0] dbg_addr,
  output logic instr_ready_r,
  output logic [`CIE_PC_W-1:0] pc_r,
  output logic [`CIE_PC_W-1:0] stack_top_entry_r,
  output logic [`CIE_DATA_W-1:0] acc_r,
  output logic zero_flag_r,
  output logic expiry_status_flag_r,
  output logic power_down_flag_r,
  output logic [`CIE_WDT_CNT_W-1:0] wdt_count_r,
  output logic [`CIE_WDT_PRE_W-1:0] wdt_prescale_r,
  output logic [`CIE_DATA_W-1:0] dbg_data
);
  import cie_pkg::*;

  logic rst_meta_r;
  logic rstn_r;
  cie_state_t state_r;
  cie_state_t state_nxt;
  logic take;
  logic file_op;
  logic [`CIE_DATA_W-1:0] dec_res;
  logic [`CIE_DATA_W-1:0] res;
  logic res_zero;
  logic skip_now;
  logic wdt_clear;
  logic pre_wrap;
  logic cnt_wrap;

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rstn_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rstn_r <= rst_meta_r;
    end
  end

  cie_rf_if rf (.clk(clk), .rstn(rstn_r));

  cie_regfile #(.DEPTH(`CIE_REG_DEPTH)) u_regfile (.rf(rf.store));

  assign dbg_data = rf.dbg_data;
  assign rf.dbg_addr = dbg_addr;

  // operand fetch and result selection
  assign take = instr_valid && instr_ready_r;
  assign file_op = (instr_op == CIE_OP_INVERT_FILE) ||
                   (instr_op == CIE_OP_FILE_DECREMENT) ||
                   (instr_op == CIE_OP_DECREMENT_SKIP);
  assign rf.raddr = instr_file;
  assign dec_res = rf.rdata - `CIE_ONE_BYTE;
  assign res_zero = (res == `CIE_ZERO_BYTE);
  assign skip_now = take && (instr_op == CIE_OP_DECREMENT_SKIP) &&
                    (dec_res == `CIE_ZERO_BYTE);
  assign wdt_clear = take && (instr_op == CIE_OP_WATCHDOG_CLEAR);

  always_comb begin
    unique case (instr_op)
      CIE_OP_INVERT_FILE: res = ~rf.rdata;
      CIE_OP_FILE_DECREMENT: res = dec_res;
      CIE_OP_DECREMENT_SKIP: res = dec_res;
      default: res = `CIE_ZERO_BYTE;
    endcase
  end

  // file register write-back
  always_comb begin
    rf.waddr = instr_file;
    rf.wdata = res;
    rf.we = take && ((file_op && instr_dest) ||
                     (instr_op == CIE_OP_ZERO_FILE));
  end

  // cycle sequencing: call and taken skip add a flush cycle
  always_comb begin
    unique case (state_r)
      CIE_ST_EXEC: begin
        if (take && (instr_op == CIE_OP_CALL)) begin
          state_nxt = CIE_ST_FLUSH;
        end else if (skip_now) begin
          state_nxt = CIE_ST_FLUSH;
        end else begin
          state_nxt = CIE_ST_EXEC;
        end
      end
      CIE_ST_FLUSH: state_nxt = CIE_ST_EXEC;
    endcase
  end

  always_ff @(posedge clk or negedge rstn_r) begin
    if (!rstn_r) begin
      state_r <= CIE_ST_EXEC;
      instr_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      instr_ready_r <= (state_nxt == CIE_ST_EXEC);
    end
  end

  // program counter
  always_ff @(posedge clk or negedge rstn_r) begin
    if (!rstn_r) begin
      pc_r <= `CIE_PC_RST;
    end else if (take) begin
      if (instr_op == CIE_OP_CALL) begin
        pc_r[`CIE_LIT_HI:0] <= instr_lit;
        pc_r[`CIE_PC_HI:`CIE_PC_UP_LO] <=
          upper_branch_latch[`CIE_LATCH_HI:`CIE_LATCH_LO];
      end else if (skip_now) begin
        pc_r <= pc_r + `CIE_SKIP_STEP;
      end else begin
        pc_r <= pc_r + `CIE_PC_STEP;
      end
    end
  end

  // stack top entry
  always_ff @(posedge clk or negedge rstn_r) begin
    if (!rstn_r) begin
      stack_top_entry_r <= `CIE_STACK_RST;
    end else if (take && (instr_op == CIE_OP_CALL)) begin
      stack_top_entry_r <= pc_r + `CIE_PC_STEP;
    end
  end

  // accumulator
  always_ff @(posedge clk or negedge rstn_r) begin
    if (!rstn_r) begin
      acc_r <= `CIE_ZERO_BYTE;
    end else if (take) begin
      if (instr_op == CIE_OP_ACCUMULATOR_ZERO) begin
        acc_r <= `CIE_ZERO_BYTE;
      end else if (file_op && !instr_dest) begin
        acc_r <= res;
      end
    end
  end

  // zero flag
  always_ff @(posedge clk or negedge rstn_r) begin
    if (!rstn_r) begin
      zero_flag_r <= 1'b0;
    end else if (take) begin
      unique case (instr_op)
        CIE_OP_INVERT_FILE: zero_flag_r <= res_zero;
        CIE_OP_FILE_DECREMENT: zero_flag_r <= res_zero;
        CIE_OP_ZERO_FILE: zero_flag_r <= 1'b1;
        CIE_OP_ACCUMULATOR_ZERO: zero_flag_r <= 1'b1;
        default: zero_flag_r <= zero_flag_r;
      endcase
    end
  end

  // watchdog prescaler and counter
  assign pre_wrap = (wdt_prescale_r == {`CIE_WDT_PRE_W{1'b1}});
  assign cnt_wrap = pre_wrap && (wdt_count_r == {`CIE_WDT_CNT_W{1'b1}});

  always_ff @(posedge clk or negedge rstn_r) begin
    if (!rstn_r) begin
      wdt_prescale_r <= `CIE_WDT_PRE_RST;
      wdt_count_r <= `CIE_WDT_CNT_RST;
    end else if (wdt_clear) begin
      wdt_prescale_r <= `CIE_WDT_PRE_RST;
      wdt_count_r <= `CIE_WDT_CNT_RST;
    end else begin
      wdt_prescale_r <= wdt_prescale_r + `CIE_WDT_PRE_ONE;
      if (pre_wrap) begin
        wdt_count_r <= wdt_count_r + `CIE_WDT_CNT_ONE;
      end
    end
  end

  // status bits: counter overflow clears expiry, clear op sets both
  always_ff @(posedge clk or negedge rstn_r) begin
    if (!rstn_r) begin
      expiry_status_flag_r <= `CIE_FLAG_RST;
      power_down_flag_r <= `CIE_FLAG_RST;
    end else if (wdt_clear) begin
      expiry_status_flag_r <= 1'b1;
      power_down_flag_r <= 1'b1;
    end else if (cnt_wrap) begin
      expiry_status_flag_r <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn_r);

  sequence s_flush_then_ready;
    !instr_ready_r ##1 instr_ready_r;
  endsequence

  sequence s_call_taken;
    take && (instr_op == CIE_OP_CALL);
  endsequence

  sequence s_skip_zero;
    take && (instr_op == CIE_OP_DECREMENT_SKIP) &&
      (rf.rdata == `CIE_ONE_BYTE);
  endsequence

  a_wdt_clear_zero: assert property (
    wdt_clear |=> (wdt_count_r == `CIE_WDT_CNT_RST) &&
      (wdt_prescale_r == `CIE_WDT_PRE_RST) ##1
      ($past(wdt_clear) || (wdt_prescale_r == `CIE_WDT_PRE_ONE)))
    else $error("watchdog not cleared");

  a_wdt_status_set: assert property (
    wdt_clear |=> expiry_status_flag_r && power_down_flag_r &&
      (zero_flag_r == $past(zero_flag_r)))
    else $error("watchdog clear status wrong");

  a_call_push_ret: assert property (
    s_call_taken |=> stack_top_entry_r == $past(pc_r) + `CIE_PC_STEP)
    else $error("call return address wrong");

  a_call_target_low: assert property (
    s_call_taken |=> pc_r[`CIE_LIT_HI:0] == $past(instr_lit))
    else $error("call low target wrong");

  a_call_target_high: assert property (
    s_call_taken |=> pc_r[`CIE_PC_HI:`CIE_PC_UP_LO] ==
      $past(upper_branch_latch[`CIE_LATCH_HI:`CIE_LATCH_LO]))
    else $error("call high target wrong");

  a_call_two_cycle: assert property (
    s_call_taken |=> (s_flush_then_ready and
      ($stable(zero_flag_r) [*2])))
    else $error("call timing or flags wrong");

  a_dest_route: assert property (
    take && file_op && !instr_dest |=> acc_r == $past(res))
    else $error("result not routed to accumulator");

  a_invert_result: assert property (
    take && (instr_op == CIE_OP_INVERT_FILE) && !instr_dest |=>
      (acc_r == ~$past(rf.rdata)) && (zero_flag_r == (acc_r == 8'h00)))
    else $error("invert result wrong");

  a_zero_file_flag: assert property (
    take && (instr_op == CIE_OP_ZERO_FILE) |->
      (rf.we && (rf.wdata == `CIE_ZERO_BYTE)) ##1 zero_flag_r)
    else $error("zero file flag not set");

  a_dec_zero_flag: assert property (
    take && (instr_op == CIE_OP_FILE_DECREMENT) |=>
      zero_flag_r == ($past(rf.rdata) == `CIE_ONE_BYTE))
    else $error("decrement zero flag wrong");

  a_acc_zero_op: assert property (
    take && (instr_op == CIE_OP_ACCUMULATOR_ZERO) |=>
      (acc_r == `CIE_ZERO_BYTE) && zero_flag_r)
    else $error("accumulator not cleared");

  a_skip_flags_kept: assert property (
    take && (instr_op == CIE_OP_DECREMENT_SKIP) |=> $stable(zero_flag_r))
    else $error("skip changed zero flag");

  a_skip_taken: assert property (
    s_skip_zero |=> (pc_r == $past(pc_r) + `CIE_SKIP_STEP) and
      s_flush_then_ready)
    else $error("skip not taken");

  a_skip_not_taken: assert property (
    take && (instr_op == CIE_OP_DECREMENT_SKIP) &&
      (rf.rdata != `CIE_ONE_BYTE) |=> instr_ready_r &&
      (pc_r == $past(pc_r) + `CIE_PC_STEP))
    else $error("skip taken wrongly");

endmodule : cie_core

`default_nettype wire

/* logic/cie_defines.svh */
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH

// widths
`define CIE_PC_W 13
`define CIE_ADDR_W 7
`define CIE_DATA_W 8
`define CIE_LIT_W 11
`define CIE_LATCH_W 8
`define CIE_WDT_CNT_W 8
`define CIE_WDT_PRE_W 8
`define CIE_REG_DEPTH 128

// field positions
`define CIE_LIT_HI 10
`define CIE_PC_HI 12
`define CIE_PC_UP_LO 11
`define CIE_LATCH_HI 4
`define CIE_LATCH_LO 3

// values
`define CIE_ZERO_BYTE 8'h00
`define CIE_ONE_BYTE 8'h01
`define CIE_PC_STEP 13'h0001
`define CIE_SKIP_STEP 13'h0002
`define CIE_PC_RST 13'h0000
`define CIE_STACK_RST 13'h0000
`define CIE_WDT_CNT_RST 8'h00
`define CIE_WDT_PRE_RST 8'h00
`define CIE_WDT_CNT_ONE 8'h01
`define CIE_WDT_PRE_ONE 8'h01
`define CIE_FLAG_RST 1'b1

// timing: call and taken skip each occupy this many cycles
`define CIE_LONG_CYC 2

`endif

/* logic/cie_pkg.sv */
package cie_pkg;

  typedef enum logic [2:0] {
    CIE_OP_NOP = 3'h0,
    CIE_OP_WATCHDOG_CLEAR = 3'h1,
    CIE_OP_CALL = 3'h2,
    CIE_OP_INVERT_FILE = 3'h3,
    CIE_OP_ZERO_FILE = 3'h4,
    CIE_OP_FILE_DECREMENT = 3'h5,
    CIE_OP_ACCUMULATOR_ZERO = 3'h6,
    CIE_OP_DECREMENT_SKIP = 3'h7
  } cie_op_t;

  typedef enum logic {
    CIE_ST_EXEC = 1'b0,
    CIE_ST_FLUSH = 1'b1
  } cie_state_t;

endpackage : cie_pkg

/* logic/cie_rf_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cie_defines.svh"

interface cie_rf_if (
  input wire logic clk,
  input wire logic rstn
);
  logic [`CIE_ADDR_W-1:0] raddr;
  logic [`CIE_DATA_W-1:0] rdata;
  logic we;
  logic [`CIE_ADDR_W-1:0] waddr;
  logic [`CIE_DATA_W-1:0] wdata;
  logic [`CIE_ADDR_W-1:0] dbg_addr;
  logic [`CIE_DATA_W-1:0] dbg_data;

  modport core (
    output raddr, we, waddr, wdata, dbg_addr,
    input rdata, dbg_data, clk, rstn
  );
  modport store (
    input raddr, we, waddr, wdata, dbg_addr, clk, rstn,
    output rdata, dbg_data
  );
endinterface : cie_rf_if

`default_nettype wire

/* logic/cie_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cie_defines.svh"

module cie_regfile #(
  parameter int DEPTH = `CIE_REG_DEPTH
) (
  cie_rf_if.store rf
);
  import cie_pkg::*;

  logic [`CIE_DATA_W-1:0] mem_r [DEPTH];
  logic [`CIE_DATA_W-1:0] dbg_r;

  // file registers, one write port
  always_ff @(posedge rf.clk or negedge rf.rstn) begin
    if (!rf.rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= `CIE_ZERO_BYTE;
      end
    end else if (rf.we) begin
      mem_r[rf.waddr] <= rf.wdata;
    end
  end

  // registered observation port
  always_ff @(posedge rf.clk or negedge rf.rstn) begin
    if (!rf.rstn) begin
      dbg_r <= `CIE_ZERO_BYTE;
    end else begin
      dbg_r <= mem_r[rf.dbg_addr];
    end
  end

  assign rf.rdata = mem_r[rf.raddr];
  assign rf.dbg_data = dbg_r;

endmodule : cie_regfile

`default_nettype wire

/* dv/test_cpu_instr_exec_subset.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cie_defines.svh"
module test_cpu_instr_exec_subset;
  import cie_pkg::*;
  logic clk, resetn, instr_valid, instr_dest, instr_ready_r, zero_flag_r;
  logic expiry_status_flag_r, power_down_flag_r;
  cie_op_t instr_op;
  logic [6:0] instr_file, dbg_addr;
  logic [10:0] instr_lit;
  logic [7:0] upper_branch_latch, acc_r, dbg_data;
  logic [7:0] wdt_count_r, wdt_prescale_r;
  logic [12:0] pc_r, stack_top_entry_r;
  int failures, compares, exp_wait;
  logic [7:0] mem [128];
  logic [7:0] m_acc;
  logic [12:0] m_pc, m_stk;
  logic m_z, m_rdy;
  logic [31:0] seed;

  cie_core i_cie_core (
    .clk(clk), .resetn(resetn), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_file(instr_file), .instr_dest(instr_dest),
    .instr_lit(instr_lit), .upper_branch_latch(upper_branch_latch),
    .dbg_addr(dbg_addr), .instr_ready_r(instr_ready_r), .pc_r(pc_r),
    .stack_top_entry_r(stack_top_entry_r), .acc_r(acc_r),
    .zero_flag_r(zero_flag_r), .expiry_status_flag_r(expiry_status_flag_r),
    .power_down_flag_r(power_down_flag_r), .wdt_count_r(wdt_count_r),
    .wdt_prescale_r(wdt_prescale_r), .dbg_data(dbg_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // expected state after one taken instruction
  task automatic model(input cie_op_t op, input logic [6:0] f,
                       input logic d, input logic [10:0] k);
    logic [7:0] r;
    r = mem[f];
    m_rdy = 1'b1;
    m_pc = m_pc + 13'h0001;
    case (op)
      CIE_OP_CALL: begin
        m_stk = m_pc;
        m_pc = {upper_branch_latch[4:3], k};
        m_rdy = 1'b0;
      end
      CIE_OP_INVERT_FILE: r = ~r;
      CIE_OP_ZERO_FILE: begin
        mem[f] = 8'h00;
        m_z = 1'b1;
      end
      CIE_OP_FILE_DECREMENT, CIE_OP_DECREMENT_SKIP: r = r - 8'h01;
      CIE_OP_ACCUMULATOR_ZERO: begin
        m_acc = 8'h00;
        m_z = 1'b1;
      end
      default: ;
    endcase
    if (op == CIE_OP_INVERT_FILE || op == CIE_OP_FILE_DECREMENT ||
        op == CIE_OP_DECREMENT_SKIP) begin
      if (d)
        mem[f] = r;
      else
        m_acc = r;
      if (op != CIE_OP_DECREMENT_SKIP)
        m_z = (r == 8'h00);
      else if (r == 8'h00) begin
        m_pc = m_pc + 13'h0001;
        m_rdy = 1'b0;
      end
    end
  endtask : model

  // offer at a falling edge, hold through refused cycles, check after take
  task automatic run(input cie_op_t op, input logic [6:0] f, input logic d,
                     input logic [10:0] k, input logic [7:0] lt);
    int n;
    instr_valid = 1'b1;
    instr_op = op;
    instr_file = f;
    instr_dest = d;
    instr_lit = k;
    upper_branch_latch = lt;
    n = 0;
    while (instr_ready_r !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk("wait", 16'(n), 16'(exp_wait));
    model(op, f, d, k);
    exp_wait = m_rdy ? 0 : 1;
    @(posedge clk);
    @(negedge clk);
    chk("pc", 16'(pc_r), 16'(m_pc));
    chk("stack", 16'(stack_top_entry_r), 16'(m_stk));
    chk("acc", 16'(acc_r), 16'(m_acc));
    chk("zero", 16'(zero_flag_r), 16'(m_z));
    chk("ready", 16'(instr_ready_r), 16'(m_rdy));
    chk("expiry", 16'(expiry_status_flag_r), 16'h0001);
    chk("pd", 16'(power_down_flag_r), 16'h0001);
    if (op == CIE_OP_WATCHDOG_CLEAR) begin
      chk("wdt_count", 16'(wdt_count_r), 16'h0000);
      chk("wdt_pre", 16'(wdt_prescale_r), 16'h0000);
    end
  endtask : run

  task automatic peek(input logic [6:0] a);
    instr_valid = 1'b0;
    dbg_addr = a;
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
    exp_wait = 0;
    chk("file", 16'(dbg_data), 16'(mem[a]));
  endtask : peek

  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr_op = CIE_OP_NOP;
    instr_file = 7'h00;
    instr_dest = 1'b0;
    instr_lit = 11'h000;
    upper_branch_latch = 8'h00;
    dbg_addr = 7'h00;
    failures = 0;
    compares = 0;
    seed = 32'hc078;
    m_acc = 8'h00;
    m_pc = 13'h0000;
    m_stk = 13'h0000;
    m_z = 1'b0;
    exp_wait = 3;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (6) @(negedge clk);
    chk("rst_pc", 16'(pc_r), 16'h0000);
    chk("rst_ready", 16'(instr_ready_r), 16'h0000);
    chk("rst_expiry", 16'(expiry_status_flag_r), 16'h0001);
    resetn = 1'b1;
    run(CIE_OP_ZERO_FILE, 7'h05, 1'b0, 11'h000, 8'h00);
    run(CIE_OP_INVERT_FILE, 7'h05, 1'b1, 11'h000, 8'h00);
    run(CIE_OP_INVERT_FILE, 7'h05, 1'b0, 11'h000, 8'h00);
    run(CIE_OP_FILE_DECREMENT, 7'h7f, 1'b1, 11'h000, 8'h00);
    run(CIE_OP_FILE_DECREMENT, 7'h7f, 1'b0, 11'h000, 8'h00);
    run(CIE_OP_ACCUMULATOR_ZERO, 7'h00, 1'b0, 11'h000, 8'h00);
    run(CIE_OP_CALL, 7'h00, 1'b0, 11'h7ff, 8'h18);
    run(CIE_OP_CALL, 7'h00, 1'b0, 11'h000, 8'he7);
    run(CIE_OP_FILE_DECREMENT, 7'h7f, 1'b1, 11'h000, 8'h00);
    run(CIE_OP_INVERT_FILE, 7'h7f, 1'b1, 11'h000, 8'h00);
    run(CIE_OP_DECREMENT_SKIP, 7'h7f, 1'b1, 11'h000, 8'h00);
    run(CIE_OP_CALL, 7'h00, 1'b0, 11'h2a5, 8'h08);
    run(CIE_OP_DECREMENT_SKIP, 7'h7f, 1'b0, 11'h000, 8'h00);
    run(CIE_OP_WATCHDOG_CLEAR, 7'h00, 1'b0, 11'h000, 8'h00);
    peek(7'h7f);
    peek(7'h05);
    $display("test corners done");
    repeat (300) begin
      seed = lfsr(seed);
      run(cie_op_t'(seed[2:0]), {4'h0, seed[5:3]}, seed[6], seed[17:7],
          seed[25:18]);
      if (seed[27:26] == 2'h0)
        peek({4'h0, seed[10:8]});
    end
    $display("test random done");
    // idle past a full watchdog wrap so the clear op has work to do
    instr_valid = 1'b0;
    repeat (65840) @(negedge clk);
    exp_wait = 0;
    chk("expiry_idle", 16'(expiry_status_flag_r), 16'h0000);
    chk("wdt_idle", 16'(wdt_count_r), 16'h0001);
    run(CIE_OP_WATCHDOG_CLEAR, 7'h00, 1'b0, 11'h000, 8'h00);
    $display("test timeout done");
    test_done;
  end

  initial begin
    #900000;
    failures++;
    test_done;
  end
endmodule : test_cpu_instr_exec_subset
`default_nettype wire
